/* File: logic/acd_clock_config.sv */
/*
 * acd_clock_config: clock divider ratio and enable registers, the
 * second-port bit clock and analog dividers, and the clock output source mux.
 * Assumes the control port, the auto-detect logic and the source ticks all
 * run on sys_clk; source ticks are one-cycle enables of their clocks.
 */
`timescale 1ns/1ps

// Behaviour
// - The second-port bit clock low code maps 0 to 512, 63 to 511, any other code to itself.
// - With automatic clock detection on, both programmed ratios give way to derived ones.
// - The analog divider code decodes 0 to 64 and every other code to itself.
// - Feedback, pre and mic dividers run only while core enable bits 2, 1 and 0 are one.
// - The playback modulator divider runs only while bit 4 of the port enables is one.
// - First and second port bit clock dividers are enabled by bits 3 and 2 independently.
// - First and second port frame dividers are enabled by bits 1 and 0 independently.
// - The output source code picks PLL, port 1 or 2 bit clock, control clock, oscillator or DSP.
module acd_clock_config (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire acd_pkg::acd_req_t req,
    input  wire logic              auto_detect_en,
    input  wire logic [9:0]        auto_sec_ratio,
    input  wire logic [6:0]        auto_ana_ratio,
    input  wire logic [5:0]        src_tick,
    output logic [7:0]             rdata_q,
    output acd_pkg::acd_run_t      run_q,
    output logic                   sec_bclk_tick_q,
    output logic                   ana_tick_q,
    output logic                   clkout_src_tick_q
);

    // register state
    logic [7:0] sec_low_q;
    logic [5:0] ana_div_q;
    logic [2:0] core_en_q;
    logic [4:0] port_en_q;
    logic [2:0] clkout_sel_q;
    logic [9:0] sec_cnt_q;
    logic [6:0] ana_cnt_q;

    // write decode per register
    wire        wr_sec  = req.wr && (req.addr == acd_pkg::ACD_OFS_SEC_BCLK_LOW);
    wire        wr_ana  = req.wr && (req.addr == acd_pkg::ACD_OFS_ANALOG_NM);
    wire        wr_core = req.wr && (req.addr == acd_pkg::ACD_OFS_CORE_EN);
    wire        wr_port = req.wr && (req.addr == acd_pkg::ACD_OFS_PORT_EN);
    wire        wr_sel  = req.wr && (req.addr == acd_pkg::ACD_OFS_CLKOUT_SEL);

    // ratio decode; auto detection overrides whatever software wrote
    function automatic logic [9:0] sec_ratio_f(input logic [7:0] code);
        if (code == 8'h00)
            return acd_pkg::ACD_SEC_RATIO_ZERO;
        else if (code == acd_pkg::ACD_SEC_CODE_TOP)
            return acd_pkg::ACD_SEC_RATIO_TOP;
        else
            return {2'h0, code};
    endfunction
    function automatic logic [6:0] ana_ratio_f(input logic [5:0] code);
        return (code == 6'h00) ? acd_pkg::ACD_ANA_RATIO_ZERO : {1'h0, code};
    endfunction

    wire [9:0]  sec_ratio = auto_detect_en ? auto_sec_ratio :
                            sec_ratio_f(sec_low_q);
    wire [6:0]  ana_ratio = auto_detect_en ? auto_ana_ratio :
                            ana_ratio_f(ana_div_q);
    wire        sec_run   = port_en_q[acd_pkg::ACD_BIT_P2_BCLK];
    wire        sec_wrap  = sec_cnt_q >= (sec_ratio - 10'h001);
    wire        ana_wrap  = ana_cnt_q >= (ana_ratio - 7'h01);

    // read mux; reserved bits and unmapped offsets read as zero
    wire [7:0]  rd_mux =
        (req.addr == acd_pkg::ACD_OFS_SEC_BCLK_LOW) ? sec_low_q :
        (req.addr == acd_pkg::ACD_OFS_ANALOG_NM)    ? {2'h0, ana_div_q} :
        (req.addr == acd_pkg::ACD_OFS_CORE_EN)      ? {5'h00, core_en_q} :
        (req.addr == acd_pkg::ACD_OFS_PORT_EN)      ? {3'h0, port_en_q} :
        (req.addr == acd_pkg::ACD_OFS_CLKOUT_SEL)   ? {5'h00, clkout_sel_q} : 8'h00;

    // source mux; reserved codes give a silent output rather than a stray clock
    wire        src_pick  = (clkout_sel_q <= acd_pkg::ACD_SRC_DSP) ?
                            src_tick[clkout_sel_q] : 1'b0;

    // writable bits only; reserved bits have no storage, so they stay read-only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_low_q    <= acd_pkg::ACD_RST_SEC_BCLK_LOW;
            ana_div_q    <= acd_pkg::ACD_RST_ANALOG_NM;
            core_en_q    <= acd_pkg::ACD_RST_CORE_EN;
            port_en_q    <= acd_pkg::ACD_RST_PORT_EN;
            clkout_sel_q <= acd_pkg::ACD_RST_CLKOUT_SEL;
        end else begin
            if (wr_sec)  sec_low_q    <= req.wdata;
            if (wr_ana)  ana_div_q    <= req.wdata[5:0];
            if (wr_core) core_en_q    <= req.wdata[2:0];
            if (wr_port) port_en_q    <= req.wdata[4:0];
            if (wr_sel)  clkout_sel_q <= req.wdata[2:0];
        end
    end

    // read data is captured so the port sees a flop, one cycle after rd
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else if (req.rd)
            rdata_q <= rd_mux;
    end

    // run levels follow the enable bits one cycle after the write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= '0;
        end else begin
            run_q.feedback_run  <= core_en_q[acd_pkg::ACD_BIT_FEEDBACK];
            run_q.pre_run       <= core_en_q[acd_pkg::ACD_BIT_PRE];
            run_q.mic_run       <= core_en_q[acd_pkg::ACD_BIT_MIC];
            run_q.modulator_run <= port_en_q[acd_pkg::ACD_BIT_MOD];
            run_q.p1_bclk_run   <= port_en_q[acd_pkg::ACD_BIT_P1_BCLK];
            run_q.p2_bclk_run   <= sec_run;
            run_q.p1_frame_run  <= port_en_q[acd_pkg::ACD_BIT_P1_FRAME];
            run_q.p2_frame_run  <= port_en_q[acd_pkg::ACD_BIT_P2_FRAME];
        end
    end

    // second-port bit clock divider: held at phase zero while disabled;
    // >= on wrap keeps a ratio shrunk mid-count from running off to 1023
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_cnt_q       <= 10'h000;
            sec_bclk_tick_q <= 1'b0;
        end else begin
            sec_cnt_q       <= (!sec_run || sec_wrap) ? 10'h000 : sec_cnt_q + 10'h001;
            sec_bclk_tick_q <= sec_run && sec_wrap;
        end
    end

    // analog divider has no enable of its own and runs from reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ana_cnt_q  <= 7'h00;
            ana_tick_q <= 1'b0;
        end else begin
            ana_cnt_q  <= ana_wrap ? 7'h00 : ana_cnt_q + 7'h01;
            ana_tick_q <= ana_wrap;
        end
    end

    // clock output source tick, one cycle behind the selected source
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            clkout_src_tick_q <= 1'b0;
        else
            clkout_src_tick_q <= src_pick;
    end

    a_sec_zero_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!auto_detect_en && sec_low_q == 8'h00) |-> sec_ratio == 10'h200)
        else $error("code 0 must give ratio 512");
    a_sec_top_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!auto_detect_en && sec_low_q == 8'h3f) |-> sec_ratio == 10'h1ff)
        else $error("code 63 must give ratio 511");
    a_auto_override: assert property (@(posedge sys_clk) disable iff (!rst_b)
        auto_detect_en |-> (sec_ratio == auto_sec_ratio && ana_ratio == auto_ana_ratio))
        else $error("auto detection must override programmed ratios");
    a_ana_period: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ($rose(ana_tick_q) && !auto_detect_en && ana_div_q == 6'h03)
            ##1 (!auto_detect_en && ana_div_q == 6'h03) [*2]
            |=> (ana_tick_q && !$past(ana_tick_q) && !$past(ana_tick_q, 2)))
        else $error("analog divide by 3 period wrong");
    a_core_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_core |=> ##1 (run_q.mic_run == $past(req.wdata[0], 2)
                         && run_q.feedback_run == $past(req.wdata[2], 2)))
        else $error("core run levels do not follow write");
    a_mod_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_port && !req.wdata[4]) |=> ##1 !run_q.modulator_run)
        else $error("modulator divider runs while disabled");
    a_port_bclk: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_port && req.wdata[3:2] == 2'h2) |=> ##1 (run_q.p1_bclk_run && !run_q.p2_bclk_run))
        else $error("bit clock enables not independent");
    a_port_frame: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wr_port && req.wdata[1:0] == 2'h1) |=> ##1 (!run_q.p1_frame_run && run_q.p2_frame_run))
        else $error("frame enables not independent");
    a_clkout_mux: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (clkout_sel_q == 3'h2 && src_tick[2] && !wr_sel) |=> clkout_src_tick_q)
        else $error("clock output does not follow selected source");
    a_div_static: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !sec_run |=> (!sec_bclk_tick_q && sec_cnt_q == 10'h000))
        else $error("disabled divider not held at phase zero");

endmodule // acd_clock_config

/* File: logic/acd_pkg.sv */
/*
 * acd_pkg: register map, field layout, reset values and carrier types
 * for the audio clock divider configuration block.
 * Assumes an 8-bit register address and 8-bit data on the control port.
 */
package acd_pkg;

    // register offsets on the control port
    localparam logic [7:0] ACD_OFS_SEC_BCLK_LOW = 8'h3d;
    localparam logic [7:0] ACD_OFS_ANALOG_NM    = 8'h3e;
    localparam logic [7:0] ACD_OFS_CORE_EN      = 8'h44;
    localparam logic [7:0] ACD_OFS_PORT_EN      = 8'h45;
    localparam logic [7:0] ACD_OFS_CLKOUT_SEL   = 8'h46;

    // values after reset
    localparam logic [7:0] ACD_RST_SEC_BCLK_LOW = 8'h01;
    localparam logic [5:0] ACD_RST_ANALOG_NM    = 6'h01;
    localparam logic [2:0] ACD_RST_CORE_EN      = 3'h0;
    localparam logic [4:0] ACD_RST_PORT_EN      = 5'h00;
    localparam logic [2:0] ACD_RST_CLKOUT_SEL   = 3'h0;

    // field positions in the core enable register
    localparam int ACD_BIT_FEEDBACK = 2;
    localparam int ACD_BIT_PRE      = 1;
    localparam int ACD_BIT_MIC      = 0;
    // field positions in the serial port enable register
    localparam int ACD_BIT_MOD      = 4;
    localparam int ACD_BIT_P1_BCLK  = 3;
    localparam int ACD_BIT_P2_BCLK  = 2;
    localparam int ACD_BIT_P1_FRAME = 1;
    localparam int ACD_BIT_P2_FRAME = 0;

    // ratio decode constants
    localparam logic [9:0] ACD_SEC_RATIO_ZERO = 10'h200; // code 0
    localparam logic [9:0] ACD_SEC_RATIO_TOP  = 10'h1ff; // code 63
    localparam logic [7:0] ACD_SEC_CODE_TOP   = 8'h3f;
    localparam logic [6:0] ACD_ANA_RATIO_ZERO = 7'h40;   // code 0

    // clock output source codes
    typedef enum logic [2:0] {
        ACD_SRC_PLL      = 3'h0,
        ACD_SRC_P1_BCLK  = 3'h1,
        ACD_SRC_P2_BCLK  = 3'h2,
        ACD_SRC_CTRL_CLK = 3'h3,
        ACD_SRC_OSC      = 3'h4,
        ACD_SRC_DSP      = 3'h5
    } acd_src_t;

    // one control port access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acd_req_t;

    // run levels handed to the clock tree
    typedef struct packed {
        logic feedback_run;
        logic pre_run;
        logic mic_run;
        logic modulator_run;
        logic p1_bclk_run;
        logic p2_bclk_run;
        logic p1_frame_run;
        logic p2_frame_run;
    } acd_run_t;

endpackage

/* File: bench/testbench.sv */
/* testbench: self-checking bench for acd_clock_config, with a register model.
   Assumes the block alone on one 25 MHz clock, driven straight at its ports. */
`timescale 1ns/1ps
module testbench;
    logic              sys_clk;
    logic              rst_b;
    acd_pkg::acd_req_t req;
    logic              auto_detect_en;
    logic [9:0]        auto_sec_ratio;
    logic [6:0]        auto_ana_ratio;
    logic [5:0]        src_tick;
    logic [7:0]        rdata_q;
    acd_pkg::acd_run_t run_q;
    logic              sec_bclk_tick_q;
    logic              ana_tick_q;
    logic              clkout_src_tick_q;
    int                fail_count;
    int                tests_run;
    int                mdl[256];
    int                p;
    int                ra;
    int                rb;
    logic              e;
    logic [7:0]        wd;
    logic [7:0]        adr[8] = '{8'h3d, 8'h3e, 8'h44, 8'h45, 8'h46, 8'h47, 8'h3c, 8'h00};
    logic [7:0]        sc[6]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h3e, 8'h3f};
    int                sr[6]  = '{10'h200, 10'h001, 10'h002, 10'h003, 10'h03e, 10'h1ff};
    logic [7:0]        ac[4]  = '{8'h00, 8'h01, 8'h03, 8'h3f};
    int                ar[4]  = '{7'h40, 7'h01, 7'h03, 7'h3f};

    acd_clock_config i_acd_clock_config (
        .sys_clk           (sys_clk),
        .rst_b             (rst_b),
        .req               (req),
        .auto_detect_en    (auto_detect_en),
        .auto_sec_ratio    (auto_sec_ratio),
        .auto_ana_ratio    (auto_ana_ratio),
        .src_tick          (src_tick),
        .rdata_q           (rdata_q),
        .run_q             (run_q),
        .sec_bclk_tick_q   (sec_bclk_tick_q),
        .ana_tick_q        (ana_tick_q),
        .clkout_src_tick_q (clkout_src_tick_q)
    );

    // 40 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // writable bits per offset; zero marks an unmapped offset
    function automatic int mask(input logic [7:0] a);
        case (a)
            8'h3d: return 8'hff;
            8'h3e: return 8'h3f;
            8'h44, 8'h46: return 8'h07;
            8'h45: return 8'h1f;
            default: return 0;
        endcase
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // strobe held for exactly one sampling edge, then dropped
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        if (mask(a) != 0) mdl[a] = d & mask(a);
    endtask

    task automatic rdchk(input logic [7:0] a);
        @(posedge sys_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(rdata_q, mdl[a], "read");
    endtask

    // cycles up to the next tick; bounded so a dead divider cannot hang
    task automatic period(input logic ana, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while ((ana ? ana_tick_q : sec_bclk_tick_q) !== 1'b1 && n < 2000);
    endtask

    // first period only aligns, since a ratio change may land mid-count
    task automatic meas(input logic ana, input int exp);
        period(ana, p);
        period(ana, p);
        chk(p, exp, "tick period");
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog: the sequence needs under 8000 cycles
    initial begin
        #(40 * 40000);
        fail_count++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h73ae));
        rst_b = 1'b0;
        req = '0;
        auto_detect_en = 1'b0;
        auto_sec_ratio = 10'h001;
        auto_ana_ratio = 7'h01;
        src_tick = 6'h00;
        fail_count = 0;
        tests_run = 0;
        mdl[8'h3d] = 8'h01;
        mdl[8'h3e] = 8'h01;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(adr[i]);
        // reserved bits and reserved source codes are kept out of random data
        for (int i = 0; i < 8; i++) begin
            wd = 8'($urandom);
            if (mask(adr[i]) != 0) wd = wd & 8'(mask(adr[i]));
            if (adr[i] == 8'h46 && wd > 8'h05) wd = wd - 8'h06;
            wr(adr[i], wd);
            rdchk(adr[i]);
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h44, 8'($urandom) & 8'h07);
            wr(8'h45, 8'($urandom) & 8'h1f);
            repeat (2) @(posedge sys_clk);
            #1;
            chk(run_q, {mdl[8'h44][2:0], mdl[8'h45][4:0]}, "run");
        end
        $display("test enables done");
        wr(8'h45, 8'h04);
        for (int i = 0; i < 6; i++) begin
            wr(8'h3d, sc[i]);
            meas(1'b0, sr[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h3e, ac[i]);
            meas(1'b1, ar[i]);
        end
        ra = 3 + $urandom % 40;
        rb = 2 + $urandom % 50;
        @(posedge sys_clk);
        auto_sec_ratio <= 10'(ra);
        auto_ana_ratio <= 7'(rb);
        auto_detect_en <= 1'b1;
        meas(1'b0, ra);
        meas(1'b1, rb);
        @(posedge sys_clk);
        auto_detect_en <= 1'b0;
        $display("test ratios done");
        wr(8'h3d, 8'h04);
        wr(8'h45, 8'h00);
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            #1;
            chk(sec_bclk_tick_q, 1'b0, "held tick");
        end
        // re-enabled divider starts at phase zero, so the first tick is a full ratio away
        wr(8'h45, 8'h04);
        period(1'b0, p);
        chk(p, 4, "restart phase");
        // codes 6 and 7 are reserved, so only the six legal sources are driven
        for (int s = 0; s < 6; s++) begin
            wr(8'h46, 8'(s));
            repeat (2) @(posedge sys_clk);
            for (int k = 0; k < 16; k++) begin
                @(posedge sys_clk);
                e = src_tick[s];
                src_tick <= 6'($urandom);
                #1;
                chk(clkout_src_tick_q, e, "clock out");
            end
        end
        $display("test clock output done");
        finish_test();
    end
endmodule // testbench
